//--- verilog/light_irq_pkg.sv
// constants, types and register map of the light interrupt qualifier
package light_irq_pkg;

    localparam logic [3:0] REG_IRQ_CTRL   = 4'h2;
    localparam logic [3:0] REG_IRQ_SOURCE = 4'h3;
    localparam logic [3:0] REG_IDENT      = 4'h4;
    localparam logic [3:0] REG_LOW_LSB    = 4'h8;
    localparam logic [3:0] REG_LOW_MSB    = 4'h9;
    localparam logic [3:0] REG_HIGH_LSB   = 4'ha;
    localparam logic [3:0] REG_HIGH_MSB   = 4'hb;

    localparam logic [7:0]  BYTE_RESET    = 8'h00;
    localparam logic [15:0] LIMIT_RESET   = 16'h0000;
    localparam logic [2:0]  PERSISTENCE_SELECT_RESET = 3'h0;
    localparam logic [1:0]  SOURCE_RESET  = 2'h0;

    // command byte: bit 7 marks a command, bit 6 clears the interrupt
    localparam int CMD_FLAG_BIT  = 7;
    localparam int CMD_CLEAR_BIT = 6;

    localparam logic [2:0] PERSISTENCE_SELECT_EVERY  = 3'h0;
    localparam logic [2:0] PERSISTENCE_SELECT_SINGLE = 3'h1;
    localparam logic [2:0] PERSISTENCE_SELECT_TENTH  = 3'h2;
    localparam logic [2:0] PERSISTENCE_SELECT_SECOND = 3'h3;

    localparam logic [1:0] SRC_GREEN = 2'h0;
    localparam logic [1:0] SRC_RED   = 2'h1;
    localparam logic [1:0] SRC_BLUE  = 2'h2;
    localparam logic [1:0] SRC_CLEAR = 2'h3;

    localparam int SYS_CLK_HZ      = 100000000;
    localparam int PERSISTENCE_SELECT_TENTH_MS  = 100;
    localparam int PERSISTENCE_SELECT_SECOND_MS = 1000;
    localparam int TENTH_CYCLES    = (SYS_CLK_HZ / 1000) * PERSISTENCE_SELECT_TENTH_MS;
    localparam int SECOND_CYCLES   = (SYS_CLK_HZ / 1000) * PERSISTENCE_SELECT_SECOND_MS;

    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef struct packed {
        logic [15:0] green;
        logic [15:0] red;
        logic [15:0] blue;
        logic [15:0] clear;
    } conv_result_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_ACK   = 3'b011,
        ST_WRITE = 3'b010,
        ST_READ  = 3'b110,
        ST_RACK  = 3'b111
    } bus_state_t;

endpackage

//--- verilog/level_sync.sv
// two flip-flop synchroniser for levels
`timescale 1ns/1ns
module level_sync #(
    parameter int               WIDTH       = 1,
    // idle level held through reset
    parameter logic [WIDTH-1:0] RESET_LEVEL = '0
) (
    input  wire logic             clk_in,
    input  wire logic             arst_n_in,
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] q_reg;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            meta_reg <= RESET_LEVEL;
            q_reg    <= RESET_LEVEL;
        end else begin
            meta_reg <= d_in;
            q_reg    <= meta_reg;
        end
    end

    assign q_out = q_reg;
endmodule

//--- verilog/result_crossing.sv
// toggle handshake carrying a word from the converter clock to the system clock
`timescale 1ns/1ns
module result_crossing #(
    parameter int WIDTH = 64
) (
    input  wire logic             src_clk_in,
    input  wire logic             dst_clk_in,
    input  wire logic             arst_n_in,
    input  wire logic             src_valid_in,
    input  wire logic [WIDTH-1:0] src_data_in,
    output logic                  dst_valid_out,
    output logic      [WIDTH-1:0] dst_data_out
);
    logic             req_reg, req_next;
    logic [WIDTH-1:0] hold_reg, hold_next;
    logic             ack_s;
    logic             req_s;
    logic             seen_reg, seen_next;
    logic             valid_reg, valid_next;
    logic [WIDTH-1:0] data_reg, data_next;

    // source side: a word is dropped while the previous one is in flight
    always_comb begin
        req_next  = req_reg;
        hold_next = hold_reg;
        if (src_valid_in && (req_reg == ack_s)) begin
            req_next  = ~req_reg;
            hold_next = src_data_in;
        end
    end

    always_ff @(posedge src_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            req_reg  <= 1'b0;
            hold_reg <= '0;
        end else begin
            req_reg  <= req_next;
            hold_reg <= hold_next;
        end
    end

    level_sync #(.WIDTH(1)) u_req_sync (
        .clk_in    (dst_clk_in),
        .arst_n_in (arst_n_in),
        .d_in      (req_reg),
        .q_out     (req_s)
    );

    level_sync #(.WIDTH(1)) u_ack_sync (
        .clk_in    (src_clk_in),
        .arst_n_in (arst_n_in),
        .d_in      (seen_reg),
        .q_out     (ack_s)
    );

    // destination side: hold_reg is stable while the toggle is seen
    always_comb begin
        seen_next  = req_s;
        valid_next = (req_s != seen_reg);
        data_next  = (req_s != seen_reg) ? hold_reg : data_reg;
    end

    always_ff @(posedge dst_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            seen_reg  <= 1'b0;
            valid_reg <= 1'b0;
            data_reg  <= '0;
        end else begin
            seen_reg  <= seen_next;
            valid_reg <= valid_next;
            data_reg  <= data_next;
        end
    end

    assign dst_valid_out = valid_reg;
    assign dst_data_out  = data_reg;
endmodule

//--- verilog/light_irq_source_persistence_select_id.sv
// serial register slave, channel compare and persistence-qualified interrupt
`timescale 1ns/1ns
module light_irq_source_persistence_select_id #(
    parameter logic [6:0]  SLAVE_ADDR    = 7'h2a,
    // arbitrary identification values
    parameter logic [3:0]  PART_NUMBER   = 4'h5,
    parameter logic [3:0]  REVISION      = 4'h2,
    parameter logic [31:0] TENTH_CYCLES  = 32'(light_irq_pkg::TENTH_CYCLES),
    parameter logic [31:0] SECOND_CYCLES = 32'(light_irq_pkg::SECOND_CYCLES)
) (
    input  wire logic                        clk_sys_in,
    input  wire logic                        arst_n_in,
    input  wire logic                        adc_clk_in,
    input  wire logic                        conv_done_in,
    input  wire light_irq_pkg::conv_result_t conv_result_in,
    input  wire logic                        scl_in,
    input  wire logic                        sda_in,
    output logic                             sda_out,
    output logic                             sda_oe_n_out,
    output logic                             int_out,
    output logic                             int_oe_n_out
);
    light_irq_pkg::conv_result_t result;
    logic                        result_valid;
    logic [1:0]                  pins_s;
    logic                        scl_s;
    logic                        sda_s;

    result_crossing #(.WIDTH($bits(light_irq_pkg::conv_result_t))) u_crossing (
        .src_clk_in    (adc_clk_in),
        .dst_clk_in    (clk_sys_in),
        .arst_n_in     (arst_n_in),
        .src_valid_in  (conv_done_in),
        .src_data_in   (conv_result_in),
        .dst_valid_out (result_valid),
        .dst_data_out  (result)
    );

    level_sync #(.WIDTH(2), .RESET_LEVEL(2'h3)) u_pin_sync (
        .clk_in    (clk_sys_in),
        .arst_n_in (arst_n_in),
        .d_in      ({scl_in, sda_in}),
        .q_out     (pins_s)
    );

    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];

    // ---------------- serial bus slave ----------------
    light_irq_pkg::bus_state_t state_reg, state_next;
    logic       scl_d_reg, scl_d_next;
    logic       sda_d_reg, sda_d_next;
    logic [7:0] shift_reg, shift_next;
    logic [3:0] bit_cnt_reg, bit_cnt_next;
    logic       rw_reg, rw_next;
    logic       first_reg, first_next;
    logic [3:0] ptr_reg, ptr_next;
    logic       sda_oe_n_reg, sda_oe_n_next;
    logic       clear_cmd;

    logic [2:0]  persistence_select_reg, persistence_select_next;
    logic [1:0]  irq_channel_select_reg, irq_channel_select_next;
    logic [15:0] low_limit_reg, low_limit_next;
    logic [15:0] high_limit_reg, high_limit_next;

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    assign scl_rise  = scl_s && !scl_d_reg;
    assign scl_fall  = !scl_s && scl_d_reg;
    assign start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s;
    assign stop_det  = scl_s && scl_d_reg && !sda_d_reg && sda_s;

    function automatic logic [7:0] read_byte(
        input logic [3:0]  addr,
        input logic [2:0]  persistence_select,
        input logic [1:0]  source,
        input logic [15:0] low,
        input logic [15:0] high
    );
        logic [7:0] value;
        value = 8'h00;
        case (addr)
            light_irq_pkg::REG_IRQ_CTRL:   value = {5'h00, persistence_select};
            light_irq_pkg::REG_IRQ_SOURCE: value = {6'h00, source};
            light_irq_pkg::REG_IDENT:      value = {PART_NUMBER, REVISION};
            light_irq_pkg::REG_LOW_LSB:    value = low[7:0];
            light_irq_pkg::REG_LOW_MSB:    value = low[15:8];
            light_irq_pkg::REG_HIGH_LSB:   value = high[7:0];
            light_irq_pkg::REG_HIGH_MSB:   value = high[15:8];
            default:                       value = 8'h00;
        endcase
        return value;
    endfunction

    always_comb begin
        logic [7:0] rd;
        rd                      = read_byte(ptr_reg, persistence_select_reg,
                                            irq_channel_select_reg, low_limit_reg,
                                            high_limit_reg);
        state_next              = state_reg;
        scl_d_next              = scl_s;
        sda_d_next              = sda_s;
        shift_next              = shift_reg;
        bit_cnt_next            = bit_cnt_reg;
        rw_next                 = rw_reg;
        first_next              = first_reg;
        ptr_next                = ptr_reg;
        sda_oe_n_next           = sda_oe_n_reg;
        clear_cmd               = 1'b0;
        persistence_select_next = persistence_select_reg;
        irq_channel_select_next = irq_channel_select_reg;
        low_limit_next          = low_limit_reg;
        high_limit_next         = high_limit_reg;
        if (start_det) begin
            state_next    = light_irq_pkg::ST_ADDR;
            bit_cnt_next  = 4'h0;
            sda_oe_n_next = 1'b1;
        end else if (stop_det) begin
            state_next    = light_irq_pkg::ST_IDLE;
            sda_oe_n_next = 1'b1;
        end else begin
            case (state_reg)
                light_irq_pkg::ST_ADDR: begin
                    if (scl_rise) begin
                        shift_next   = {shift_reg[6:0], sda_s};
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                    end else if (scl_fall && bit_cnt_reg == light_irq_pkg::BITS_PER_BYTE) begin
                        bit_cnt_next = 4'h0;
                        if (shift_reg[7:1] == SLAVE_ADDR) begin
                            rw_next       = shift_reg[0];
                            first_next    = !shift_reg[0];
                            sda_oe_n_next = 1'b0;
                            state_next    = light_irq_pkg::ST_ACK;
                        end else begin
                            state_next = light_irq_pkg::ST_IDLE;
                        end
                    end
                end
                light_irq_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        if (rw_reg) begin
                            shift_next    = rd;
                            sda_oe_n_next = rd[7];
                            bit_cnt_next  = 4'h1;
                            ptr_next      = ptr_reg + 4'h1;
                            state_next    = light_irq_pkg::ST_READ;
                        end else begin
                            sda_oe_n_next = 1'b1;
                            state_next    = light_irq_pkg::ST_WRITE;
                        end
                    end
                end
                light_irq_pkg::ST_WRITE: begin
                    if (scl_rise) begin
                        shift_next   = {shift_reg[6:0], sda_s};
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                    end else if (scl_fall && bit_cnt_reg == light_irq_pkg::BITS_PER_BYTE) begin
                        bit_cnt_next  = 4'h0;
                        sda_oe_n_next = 1'b0;
                        state_next    = light_irq_pkg::ST_ACK;
                        if (first_reg) begin
                            first_next = 1'b0;
                            ptr_next   = shift_reg[3:0];
                            clear_cmd  = shift_reg[light_irq_pkg::CMD_FLAG_BIT]
                                         && shift_reg[light_irq_pkg::CMD_CLEAR_BIT];
                        end else begin
                            ptr_next = ptr_reg + 4'h1;
                            case (ptr_reg)
                                light_irq_pkg::REG_IRQ_CTRL:
                                    persistence_select_next = shift_reg[2:0];
                                light_irq_pkg::REG_IRQ_SOURCE:
                                    irq_channel_select_next = shift_reg[1:0];
                                light_irq_pkg::REG_LOW_LSB:  low_limit_next[7:0]   = shift_reg;
                                light_irq_pkg::REG_LOW_MSB:  low_limit_next[15:8]  = shift_reg;
                                light_irq_pkg::REG_HIGH_LSB: high_limit_next[7:0]  = shift_reg;
                                light_irq_pkg::REG_HIGH_MSB: high_limit_next[15:8] = shift_reg;
                                default: ;
                            endcase
                        end
                    end
                end
                light_irq_pkg::ST_READ: begin
                    if (scl_fall) begin
                        if (bit_cnt_reg == light_irq_pkg::BITS_PER_BYTE) begin
                            sda_oe_n_next = 1'b1;
                            bit_cnt_next  = 4'h0;
                            state_next    = light_irq_pkg::ST_RACK;
                        end else begin
                            sda_oe_n_next = shift_reg[6];
                            shift_next    = {shift_reg[6:0], 1'b0};
                            bit_cnt_next  = bit_cnt_reg + 4'h1;
                        end
                    end
                end
                light_irq_pkg::ST_RACK: begin
                    if (scl_rise) begin
                        shift_next[0] = sda_s;
                    end else if (scl_fall) begin
                        if (shift_reg[0]) begin
                            state_next = light_irq_pkg::ST_IDLE;
                        end else begin
                            shift_next    = rd;
                            sda_oe_n_next = rd[7];
                            bit_cnt_next  = 4'h1;
                            ptr_next      = ptr_reg + 4'h1;
                            state_next    = light_irq_pkg::ST_READ;
                        end
                    end
                end
                light_irq_pkg::ST_IDLE: ;
                default: begin
                    state_next    = light_irq_pkg::ST_IDLE;
                    sda_oe_n_next = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_reg              <= light_irq_pkg::ST_IDLE;
            scl_d_reg              <= 1'b1;
            sda_d_reg              <= 1'b1;
            shift_reg              <= light_irq_pkg::BYTE_RESET;
            bit_cnt_reg            <= 4'h0;
            rw_reg                 <= 1'b0;
            first_reg              <= 1'b0;
            ptr_reg                <= 4'h0;
            sda_oe_n_reg           <= 1'b1;
            persistence_select_reg <= light_irq_pkg::PERSISTENCE_SELECT_RESET;
            irq_channel_select_reg <= light_irq_pkg::SOURCE_RESET;
            low_limit_reg          <= light_irq_pkg::LIMIT_RESET;
            high_limit_reg         <= light_irq_pkg::LIMIT_RESET;
        end else begin
            state_reg              <= state_next;
            scl_d_reg              <= scl_d_next;
            sda_d_reg              <= sda_d_next;
            shift_reg              <= shift_next;
            bit_cnt_reg            <= bit_cnt_next;
            rw_reg                 <= rw_next;
            first_reg              <= first_next;
            ptr_reg                <= ptr_next;
            sda_oe_n_reg           <= sda_oe_n_next;
            persistence_select_reg <= persistence_select_next;
            irq_channel_select_reg <= irq_channel_select_next;
            low_limit_reg          <= low_limit_next;
            high_limit_reg         <= high_limit_next;
        end
    end

    // ---------------- compare and persistence ----------------
    logic [15:0] selected;
    logic        out_of_range;
    logic        run_active_reg, run_active_next;
    logic [31:0] run_cnt_reg, run_cnt_next;
    logic        irq_flag_reg, irq_flag_next;
    logic        irq_oe_n_reg;
    logic        raise;

    always_comb begin
        case (irq_channel_select_reg)
            light_irq_pkg::SRC_GREEN: selected = result.green;
            light_irq_pkg::SRC_RED:   selected = result.red;
            light_irq_pkg::SRC_BLUE:  selected = result.blue;
            light_irq_pkg::SRC_CLEAR: selected = result.clear;
            default:                  selected = result.green;
        endcase
        out_of_range = (selected <= low_limit_reg) || (selected > high_limit_reg);
    end

    always_comb begin
        run_active_next = run_active_reg;
        run_cnt_next    = run_cnt_reg;
        if (run_active_reg && run_cnt_reg != 32'hffffffff) begin
            run_cnt_next = run_cnt_reg + 32'h1;
        end
        raise = 1'b0;
        if (result_valid) begin
            if (!out_of_range) begin
                run_active_next = 1'b0;
                run_cnt_next    = 32'h0;
            end else if (!run_active_reg) begin
                run_active_next = 1'b1;
                run_cnt_next    = 32'h0;
            end
            case (persistence_select_reg)
                light_irq_pkg::PERSISTENCE_SELECT_EVERY:  raise = 1'b1;
                light_irq_pkg::PERSISTENCE_SELECT_SINGLE: raise = out_of_range;
                light_irq_pkg::PERSISTENCE_SELECT_TENTH:
                    raise = out_of_range && run_active_reg && run_cnt_reg >= TENTH_CYCLES;
                light_irq_pkg::PERSISTENCE_SELECT_SECOND:
                    raise = out_of_range && run_active_reg && run_cnt_reg >= SECOND_CYCLES;
                default: raise = 1'b0;
            endcase
        end
        // set wins over a clear in the same cycle
        irq_flag_next = raise ? 1'b1 : (clear_cmd ? 1'b0 : irq_flag_reg);
    end

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            run_active_reg <= 1'b0;
            run_cnt_reg    <= 32'h0;
            irq_flag_reg   <= 1'b0;
            irq_oe_n_reg   <= 1'b1;
        end else begin
            run_active_reg <= run_active_next;
            run_cnt_reg    <= run_cnt_next;
            irq_flag_reg   <= irq_flag_next;
            irq_oe_n_reg   <= !irq_flag_next;
        end
    end

    logic pin_low_reg;

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pin_low_reg <= 1'b0;
        end else begin
            pin_low_reg <= 1'b0;
        end
    end

    assign sda_out      = pin_low_reg;
    assign sda_oe_n_out = sda_oe_n_reg;
    assign int_out      = pin_low_reg;
    assign int_oe_n_out = irq_oe_n_reg;
endmodule

//--- verification/light_irq_checker_assertions.sv
// port checks of the light interrupt qualifier
`timescale 1ns/1ns
module light_irq_checker (
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    input wire logic conv_done_in,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe_n_out,
    input wire logic int_out,
    input wire logic int_oe_n_out
);
    logic [7:0] conv_age;
    logic [7:0] scl_age;
    logic [7:0] high_run;
    logic       scl_q;
    function automatic logic [7:0] inc(input logic [7:0] v);
        return v + 8'(v != 8'hff);
    endfunction
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            conv_age <= 8'hff;
            scl_age <= 8'hff;
            high_run <= 8'h00;
            scl_q <= 1'b1;
        end else begin
            conv_age <= conv_done_in ? 8'h00 : inc(conv_age);
            scl_age <= (scl_in != scl_q) ? 8'h00 : inc(scl_age);
            high_run <= scl_in ? inc(high_run) : 8'h00;
            scl_q <= scl_in;
        end
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!arst_n_in);
    chk_sda_level_low: assert property (sda_out == 1'b0)
        else $error("sda level driven high");
    chk_int_level_low: assert property (int_out == 1'b0)
        else $error("int level driven high");
    chk_int_after_conv: assert property (
        $fell(int_oe_n_out) |-> conv_age < 8'h14) else $error("int raised without conversion");
    chk_int_release_bus: assert property (
        $rose(int_oe_n_out) |-> scl_age < 8'h1e) else $error("int released without bus traffic");
    chk_int_quiet_start: assert property ($rose(arst_n_in) |-> int_oe_n_out [*4])
        else $error("int active after reset");
    chk_ack_scl_low: assert property ($fell(sda_oe_n_out) |-> !scl_in)
        else $error("sda pulled while scl high");
    chk_sda_hold_high: assert property ((scl_in && high_run > 8'h04) |-> $stable(sda_oe_n_out))
        else $error("sda moved while scl high");
    chk_sda_idle_free: assert property (high_run > 8'h0e |-> sda_oe_n_out)
        else $error("sda held on idle bus");
    chk_sda_pull_width: assert property ($fell(sda_oe_n_out) |-> !sda_oe_n_out [*8])
        else $error("sda pull too short");
    cover property (conv_done_in ##[1:20] $fell(int_oe_n_out));
    cover property ($rose(int_oe_n_out));
    cover property ($fell(sda_oe_n_out));
endmodule

//--- verification/smb_host_model.sv
// serial bus host model driving clock and data
`timescale 1ns/1ns
module smb_host_model (
    input  wire logic clk_in,
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_low_out
);
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    task automatic w(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic edge4(input logic a, input logic b, input logic c, input logic d);
        scl_out <= a;
        w(5);
        sda_low_out <= b;
        w(5);
        scl_out <= c;
        w(10);
        sda_low_out <= d;
        w(10);
    endtask
    task automatic start();
        edge4(1'b0, 1'b0, 1'b1, 1'b1);
    endtask
    task automatic stop();
        edge4(1'b0, 1'b1, 1'b1, 1'b0);
    endtask
    // data changes only while scl is low
    task automatic bit_io(input logic b, output logic r);
        scl_out <= 1'b0;
        w(5);
        sda_low_out <= ~b;
        w(5);
        scl_out <= 1'b1;
        w(5);
        r = sda_in;
        w(5);
    endtask
    task automatic xfer(input logic [7:0] d, input logic a_in, output logic [7:0] q,
                        output logic ack);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(a_in, ack);
    endtask
endmodule

//--- verification/light_irq_source_persistence_select_id_tb.sv
// self-checking bench for the light interrupt qualifier
`timescale 1ns/1ns
module light_irq_source_persistence_select_id_tb;
    // arbitrary identification value
    localparam logic [7:0] IDENT = 8'h93;
    logic clk = 1'b0, adc = 1'b0, rst_n = 1'b0, done = 1'b0;
    light_irq_pkg::conv_result_t res = '0;
    logic scl, hlow, sda_o, sda_oe_n, int_o, int_oe_n, sda;
    int   fails = 0, num_checks = 0;
    always #5 clk = ~clk;
    always #24 adc = ~adc;
    assign sda = ~hlow & sda_oe_n;
    smb_host_model host (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_low_out(hlow));
    light_irq_source_persistence_select_id #(.PART_NUMBER(IDENT[7:4]), .REVISION(IDENT[3:0]),
        .TENTH_CYCLES(32'd160), .SECOND_CYCLES(32'd2480)) uut (.clk_sys_in(clk),
        .arst_n_in(rst_n), .adc_clk_in(adc), .conv_done_in(done), .conv_result_in(res),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_o), .sda_oe_n_out(sda_oe_n),
        .int_out(int_o), .int_oe_n_out(int_oe_n));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        num_checks++;
        if (s !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] b[$]);
        logic [7:0] q;
        logic a;
        host.start();
        host.xfer(8'h54, 1'b1, q, a);
        chk("ack", 8'h00, {7'h0, a});
        foreach (b[i]) host.xfer(b[i], 1'b1, q, a);
        host.stop();
    endtask
    task automatic rd(input logic [7:0] p, input logic [7:0] e);
        logic [7:0] q;
        logic a;
        wr('{p});
        host.start();
        host.xfer(8'h55, 1'b1, q, a);
        host.xfer(8'hff, 1'b1, q, a);
        host.stop();
        chk("reg", e, q);
    endtask
    task automatic conv(input logic [15:0] sel, input logic [1:0] s, input logic [15:0] oth);
        logic [63:0] v;
        v = {4{oth}};
        v[(3 - s) * 16 +: 16] = sel;
        @(posedge adc);
        done <= 1'b1;
        res <= v;
        @(posedge adc);
        done <= 1'b0;
        host.w(100);
    endtask
    task automatic cv(input logic [15:0] sel, input logic [1:0] s, input logic e);
        wr('{8'hc0});
        conv(sel, s, 16'h0450 - sel);
        chk("int", {7'h0, e}, {7'h0, ~int_oe_n});
        $display("compare done source %0d value %h", s, sel);
    endtask
    task automatic run(input logic [2:0] p, input int n);
        wr('{8'h02, {5'h0, p}});
        wr('{8'hc0});
        for (int i = 0; i < n; i++) begin
            conv(i == 2 ? 16'h0150 : 16'h0300, 2'h3, 16'h0150);
            if (i >= n - 2) chk("persistence_select", {7'h0, i == n - 1}, {7'h0, ~int_oe_n});
        end
        $display("persistence run %0d done", p);
    endtask
    task automatic reg_map();
        rd(8'h03, 8'h00);
        rd(8'h0b, 8'h00);
        rd(8'h04, IDENT);
        wr('{8'h04, 8'h00});
        rd(8'h04, IDENT);
        rd(8'h0f, 8'h00);
        wr('{8'h08, 8'h00, 8'h01, 8'h00, 8'h02});
        wr('{8'h02, 8'h01});
        rd(8'h02, 8'h01);
        $display("register map checks done");
    endtask
    initial begin
        #800000;
        fails++;
        close_out();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        host.w(4);
        reg_map();
        for (int s = 0; s < 4; s++) begin
            wr('{8'h03, 8'(s)});
            rd(8'h03, 8'(s));
            cv(16'h0300, 2'(s), 1'b1);
            cv(16'h0150, 2'(s), 1'b0);
        end
        cv(16'h0100, 2'h3, 1'b1);
        cv(16'h0200, 2'h3, 1'b0);
        wr('{8'h02, 8'h00});
        cv(16'h0180, 2'h3, 1'b1);
        run(3'h2, 6);
        run(3'h3, 28);
        // codes 1xx never raise
        wr('{8'h02, 8'h04});
        cv(16'h0300, 2'h3, 1'b0);
        close_out();
    end
endmodule
bind light_irq_source_persistence_select_id light_irq_checker chk_i (.clk_sys_in(clk_sys_in),
    .arst_n_in(arst_n_in), .conv_done_in(conv_done_in), .scl_in(scl_in),
    .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out), .int_out(int_out),
    .int_oe_n_out(int_oe_n_out));
